// ### bench/serial_config_port_sva.sv
// assertion checker bound to the configuration port top
`timescale 1ns/1ps
`default_nettype none
module serial_config_port_sva #(
   parameter HW_RESET_MAX_CYCLES = 200
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic reset_pin_i,
   input wire logic serial_select_n_i,
   input wire logic serial_shift_clock_i,
   input wire logic serial_out_line_o,
   input wire logic serial_out_line_oe_o,
   input wire logic pin_strap_mode_o,
   input wire logic readback_enable_o,
   input wire logic [3:0] power_mode_o,
   input wire logic [3:0] gain_setting_a_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   logic sclk_q;
   logic [4:0] falls;
   int pin_cnt;
   // raw falling edges in the frame; saturates so long frames cannot wrap
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sclk_q <= 1'b1;
         falls <= 5'h00;
         pin_cnt <= 0;
      end else begin
         sclk_q <= serial_shift_clock_i;
         pin_cnt <= reset_pin_i ? pin_cnt + 1 : 0;
         if (serial_select_n_i) begin
            falls <= 5'h00;
         end else if (sclk_q && !serial_shift_clock_i && falls != 5'h1F) begin
            falls <= falls + 5'h01;
         end
      end
   end
   a_oe_always: assert property (serial_out_line_oe_o)
      else $error("output enable dropped");
   a_out_low_off: assert property (!readback_enable_o |-> !serial_out_line_o)
      else $error("readback line high while readback off");
   a_out_idle_low: assert property (serial_select_n_i [*6] |-> !serial_out_line_o)
      else $error("readback line high outside a frame");
   a_out_after_addr: assert property (serial_out_line_o && !serial_select_n_i |-> falls >= 5'h08)
      else $error("readback bit before address complete");
   a_strap_long: assert property ($rose(pin_strap_mode_o) |-> pin_cnt >= HW_RESET_MAX_CYCLES)
      else $error("strap mode on a short reset pulse");
   a_strap_set: assert property (pin_cnt > HW_RESET_MAX_CYCLES + 6 |-> pin_strap_mode_o)
      else $error("strap mode missing on a long reset pulse");
   a_pin_clears: assert property (reset_pin_i [*5] |-> !readback_enable_o && gain_setting_a_o == 4'h0 && power_mode_o == 4'h0)
      else $error("reset pin did not clear registers");
   a_idle_hold: assert property ((serial_select_n_i && !reset_pin_i) [*8] |-> $stable(gain_setting_a_o) && $stable(power_mode_o))
      else $error("register changed without a frame");
   a_write_locked: assert property (@(posedge clk_i) disable iff (!rst_b_i || reset_pin_i) readback_enable_o |=> $stable(gain_setting_a_o) || !readback_enable_o)
      else $error("register written while readback on");
   c_strap: cover property ($rose(pin_strap_mode_o));
   c_readback_bit: cover property (serial_out_line_o);
   c_readback_on: cover property ($rose(readback_enable_o));
endmodule
bind serial_config_port serial_config_port_sva #(.HW_RESET_MAX_CYCLES(HW_RESET_MAX_CYCLES)) sva_i (.*);
`default_nettype wire

// ### bench/serial_config_port_tb.sv
// self-checking bench: writes, readback, write lock, frame lengths and resets
`timescale 1ns/1ps
`default_nettype none
`include "serial_config_regs.vh"
module serial_config_port_tb;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic reset_pin_i = 1'b0;
   wire serial_select_n_i, serial_shift_clock_i, serial_in_line_i, serial_out_line_o;
   wire serial_out_line_oe_o, pin_strap_mode_o, readback_enable_o, low_rate_mode_o;
   wire standby_o, output_is_lvds_o, chan_ctrl_enable_o, offset_loop_a_o;
   wire [1:0] reference_select_o;
   wire [3:0] power_mode_o, gain_setting_a_o, offset_tc_a_o;
   wire [5:0] clock_edge_o;
   wire [13:0] user_pattern_o;
   wire [38:0] field_bus = {low_rate_mode_o, reference_select_o, standby_o, power_mode_o,
      output_is_lvds_o, clock_edge_o, chan_ctrl_enable_o, user_pattern_o, offset_loop_a_o,
      gain_setting_a_o, offset_tc_a_o};
   int failures = 0;
   int comparisons = 0;
   int i;
   logic [7:0] rd;
   logic [7:0] wa [10] = '{`ADDR_GAIN_TC_A, `ADDR_REFERENCE, `ADDR_LOW_RATE, `ADDR_POWER_STATE,
      `ADDR_OUTPUT_IF, `ADDR_CLOCK_EDGE, `ADDR_CHAN_ENABLE, `ADDR_PATTERN_LOW,
      `ADDR_PATTERN_HIGH, `ADDR_OFFSET_LOOP_A};
   logic [7:0] wm [10] = '{`MASK_GAIN_TC_A, `MASK_REFERENCE, `MASK_LOW_RATE, `MASK_POWER_STATE,
      `MASK_OUTPUT_IF, `MASK_CLOCK_EDGE, `MASK_CHAN_ENABLE, `MASK_PATTERN_LOW,
      `MASK_PATTERN_HIGH, `MASK_OFFSET_LOOP_A};
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   serial_config_port #(.HW_RESET_MAX_CYCLES(20)) uut (.*);
   serial_controller_model ctrl (.clk_i(clk_i), .serial_select_n_o(serial_select_n_i),
      .serial_shift_clock_o(serial_shift_clock_i), .serial_in_line_o(serial_in_line_i),
      .serial_out_line_i(serial_out_line_o));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      ctrl.frame({16'h0000, a, d}, 16, rd);
      repeat (8) @(posedge clk_i);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      ctrl.frame({16'h0000, a, 8'h00}, 16, rd);
      chk("readback", {40'h0, exp}, {40'h0, rd});
      repeat (8) @(posedge clk_i);
   endtask
   // pin pulse; strap state is looked at just before release
   task automatic pulse(input int n, input logic strap);
      @(posedge clk_i);
      #1.5;
      reset_pin_i = 1'b1;
      repeat (n) @(posedge clk_i);
      chk("strap", {47'h0, strap}, {47'h0, pin_strap_mode_o});
      #1.5;
      reset_pin_i = 1'b0;
      repeat (20) @(posedge clk_i);
      chk("fields", 48'h0, {9'h0, field_bus});
   endtask
   task results;
      if (failures == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk_i);
      #1.5;
      rst_b_i = 1'b1;
      repeat (20) @(posedge clk_i);
      chk("pins", 48'h8, {serial_out_line_oe_o, pin_strap_mode_o, readback_enable_o, serial_out_line_o});
      chk("fields", 48'h0, {9'h0, field_bus});
      for (i = 0; i < 10; i++) begin
         wr(wa[i], 8'hF7);
      end
      chk("fields", {9'h0, 4'hF, 4'h7, 1'b1, 6'h3D, 1'b1, 14'h37F7, 1'b1, 4'hF, 4'h7}, {9'h0, field_bus});
      wr(`ADDR_RESET_READBACK, 8'h01);
      chk("readback enable", 48'h1, {47'h0, readback_enable_o});
      // every register but 0x00: locked write, then readback of the old value
      for (i = 0; i < 10; i++) begin
         wr(wa[i], 8'h08);
         rdchk(wa[i], 8'hF7 & wm[i]);
      end
      rdchk(8'h7E, 8'h00);
      wr(`ADDR_RESET_READBACK, 8'h00);
      chk("pins", 48'h8, {serial_out_line_oe_o, pin_strap_mode_o, readback_enable_o, serial_out_line_o});
      // tail of four bits dropped, then two words in one select
      ctrl.frame({12'h000, `ADDR_OUTPUT_IF, 8'h00, 4'hF}, 20, rd);
      ctrl.frame({`ADDR_POWER_STATE, 8'h08, `ADDR_GAIN_TC_A, 8'h3C}, 32, rd);
      repeat (8) @(posedge clk_i);
      chk("fields", {9'h0, 4'hF, 4'h8, 1'b0, 6'h3D, 1'b1, 14'h37F7, 1'b1, 4'h3, 4'hC}, {9'h0, field_bus});
      wr(`ADDR_RESET_READBACK, 8'h01);
      rdchk(`ADDR_OUTPUT_IF, 8'h00);
      rdchk(`ADDR_POWER_STATE, 8'h08);
      wr(`ADDR_RESET_READBACK, 8'h81);
      chk("fields", 48'h0, {8'h0, readback_enable_o, field_bus});
      wr(`ADDR_RESET_READBACK, 8'h01);
      rdchk(`ADDR_RESET_READBACK, 8'h01);
      wr(`ADDR_RESET_READBACK, 8'h00);
      wr(`ADDR_GAIN_TC_A, 8'hA5);
      chk("fields", 48'hA5, {9'h0, field_bus});
      pulse(10, 1'b0);
      pulse(30, 1'b1);
      wr(`ADDR_GAIN_TC_A, 8'h5A);
      chk("fields", 48'h5A, {9'h0, field_bus});
      results();
   end
endmodule
`default_nettype wire

// ### bench/serial_controller_model.sv
// behavioural serial controller: frames words and samples readback bits
`timescale 1ns/1ps
`default_nettype none
module serial_controller_model (
   input wire logic clk_i,
   output logic serial_select_n_o,
   output logic serial_shift_clock_o,
   output logic serial_in_line_o,
   input wire logic serial_out_line_i
);
   // shift clock idles high and stands still between frames
   initial begin
      serial_select_n_o = 1'b1;
      serial_shift_clock_o = 1'b1;
      serial_in_line_o = 1'b0;
   end
   task automatic frame(input logic [31:0] w, input int n, output logic [7:0] r);
      int i;
      r = 8'h00;
      @(posedge clk_i);
      #1.5;
      serial_select_n_o = 1'b0;
      #24;
      for (i = n - 1; i >= 0; i--) begin
         serial_in_line_o = w[i];
         #24;
         if (i % 16 < 8) begin
            r[i % 8] = serial_out_line_i;
         end
         serial_shift_clock_o = 1'b0;
         #24;
         serial_shift_clock_o = 1'b1;
      end
      #24;
      serial_select_n_o = 1'b1;
      // released data line must not keep showing the last bit
      serial_in_line_o = ~serial_in_line_o;
   endtask
endmodule
`default_nettype wire

// ### rtl/serial_config_port.v
// configuration port top: serial register file with readback and reset sequencing
`timescale 1ns/1ps
`default_nettype none
`include "serial_config_regs.vh"
module serial_config_port #(
   parameter HW_RESET_MAX_CYCLES = `HW_RESET_MAX_CYCLES
) (
   input wire clk_i,
   input wire rst_b_i,
   input wire reset_pin_i,
   input wire serial_select_n_i,
   input wire serial_shift_clock_i,
   input wire serial_in_line_i,
   output reg serial_out_line_o,
   output wire serial_out_line_oe_o,
   output reg pin_strap_mode_o,
   output reg readback_enable_o,
   output reg low_rate_mode_o,
   output reg [1:0] reference_select_o,
   output reg standby_o,
   output reg [3:0] power_mode_o,
   output reg output_is_lvds_o,
   output reg [5:0] clock_edge_o,
   output reg chan_ctrl_enable_o,
   output reg [13:0] user_pattern_o,
   output reg offset_loop_a_o,
   output reg [3:0] gain_setting_a_o,
   output reg [3:0] offset_tc_a_o
);
   ////////////////////////////////////////////////////////////////////////////////
   reg [1:0] rst_pin_sync;
   reg [31:0] pulse_count;
   reg pulse_long;
   reg [7:0] reg_reset_readback;
   reg [7:0] reg_low_rate;
   reg [7:0] reg_reference;
   reg [7:0] reg_power_state;
   reg [7:0] reg_output_if;
   reg [7:0] reg_clock_edge;
   reg [7:0] reg_chan_enable;
   reg [7:0] reg_pattern_low;
   reg [7:0] reg_pattern_high;
   reg [7:0] reg_offset_loop_a;
   reg [7:0] reg_gain_tc_a;
   reg [7:0] read_data;
   wire [7:0] read_addr;
   wire word_valid;
   wire [15:0] word;
   wire shifted_out;
   wire hw_reset;
   wire [7:0] wr_addr;
   wire [7:0] wr_data;
   wire write_ok;
   wire soft_reset;
   // output is a cmos driver, always enabled, never floating
   assign serial_out_line_oe_o = 1'b1;
   assign hw_reset = rst_pin_sync[1];
   assign wr_addr = word[15:8];
   assign wr_data = word[7:0];
   assign write_ok = word_valid & ~reg_reset_readback[`BIT_READBACK_ENABLE];
   // writes to 0x00 pass the readback lock, so a soft reset does too
   assign soft_reset = word_valid & (wr_addr == `ADDR_RESET_READBACK) &
      wr_data[`BIT_SOFT_RESET];

   ////////////////////////////////////////////////////////////////////////////////
   // reset pin synchroniser and long-pulse detector
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_pin_sync <= 2'h0;
         pulse_count <= 32'h0000_0000;
         pulse_long <= 1'b0;
         pin_strap_mode_o <= 1'b0;
      end else begin
         rst_pin_sync <= {rst_pin_sync[0], reset_pin_i};
         if (hw_reset) begin
            if (pulse_count < HW_RESET_MAX_CYCLES) begin
               pulse_count <= pulse_count + 32'h0000_0001;
            end else begin
               pulse_long <= 1'b1;
            end
         end else begin
            pulse_count <= 32'h0000_0000;
            pulse_long <= 1'b0;
         end
         // a pin held high past the limit means pin-strapped operation
         pin_strap_mode_o <= pulse_long;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   function [7:0] masked;
      input [7:0] value;
      input [7:0] mask;
      begin
         masked = value & mask;
      end
   endfunction

   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_reset_readback <= `REG_RESET_VALUE;
         reg_low_rate <= `REG_RESET_VALUE;
         reg_reference <= `REG_RESET_VALUE;
         reg_power_state <= `REG_RESET_VALUE;
         reg_output_if <= `REG_RESET_VALUE;
         reg_clock_edge <= `REG_RESET_VALUE;
         reg_chan_enable <= `REG_RESET_VALUE;
         reg_pattern_low <= `REG_RESET_VALUE;
         reg_pattern_high <= `REG_RESET_VALUE;
         reg_offset_loop_a <= `REG_RESET_VALUE;
         reg_gain_tc_a <= `REG_RESET_VALUE;
      end else if (hw_reset || soft_reset) begin
         // reset bit is never stored, so it reads back as zero
         reg_reset_readback <= `REG_RESET_VALUE;
         reg_low_rate <= `REG_RESET_VALUE;
         reg_reference <= `REG_RESET_VALUE;
         reg_power_state <= `REG_RESET_VALUE;
         reg_output_if <= `REG_RESET_VALUE;
         reg_clock_edge <= `REG_RESET_VALUE;
         reg_chan_enable <= `REG_RESET_VALUE;
         reg_pattern_low <= `REG_RESET_VALUE;
         reg_pattern_high <= `REG_RESET_VALUE;
         reg_offset_loop_a <= `REG_RESET_VALUE;
         reg_gain_tc_a <= `REG_RESET_VALUE;
      end else if (word_valid && wr_addr == `ADDR_RESET_READBACK) begin
         // the readback bit itself stays writable so it can be cleared
         reg_reset_readback <= masked(wr_data, `MASK_RESET_READBACK);
      end else if (write_ok) begin
         case (wr_addr)
            `ADDR_LOW_RATE: reg_low_rate <= masked(wr_data, `MASK_LOW_RATE);
            `ADDR_REFERENCE: reg_reference <= masked(wr_data, `MASK_REFERENCE);
            `ADDR_POWER_STATE: reg_power_state <= masked(wr_data, `MASK_POWER_STATE);
            `ADDR_OUTPUT_IF: reg_output_if <= masked(wr_data, `MASK_OUTPUT_IF);
            `ADDR_CLOCK_EDGE: reg_clock_edge <= masked(wr_data, `MASK_CLOCK_EDGE);
            `ADDR_CHAN_ENABLE: reg_chan_enable <= masked(wr_data, `MASK_CHAN_ENABLE);
            `ADDR_PATTERN_LOW: reg_pattern_low <= masked(wr_data, `MASK_PATTERN_LOW);
            `ADDR_PATTERN_HIGH: reg_pattern_high <= masked(wr_data, `MASK_PATTERN_HIGH);
            `ADDR_OFFSET_LOOP_A: reg_offset_loop_a <= masked(wr_data, `MASK_OFFSET_LOOP_A);
            `ADDR_GAIN_TC_A: reg_gain_tc_a <= masked(wr_data, `MASK_GAIN_TC_A);
            default: reg_low_rate <= reg_low_rate;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // readback mux returns the output interface select like every other register
   always @* begin
      case (read_addr)
         `ADDR_RESET_READBACK: read_data = reg_reset_readback;
         `ADDR_LOW_RATE: read_data = reg_low_rate;
         `ADDR_REFERENCE: read_data = reg_reference;
         `ADDR_POWER_STATE: read_data = reg_power_state;
         `ADDR_OUTPUT_IF: read_data = reg_output_if;
         `ADDR_CLOCK_EDGE: read_data = reg_clock_edge;
         `ADDR_CHAN_ENABLE: read_data = reg_chan_enable;
         `ADDR_PATTERN_LOW: read_data = reg_pattern_low;
         `ADDR_PATTERN_HIGH: read_data = reg_pattern_high;
         `ADDR_OFFSET_LOOP_A: read_data = reg_offset_loop_a;
         `ADDR_GAIN_TC_A: read_data = reg_gain_tc_a;
         default: read_data = 8'h00;
      endcase
   end

   serial_frame_shifter u_shifter (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .sclk_i(serial_shift_clock_i),
      .select_n_i(serial_select_n_i),
      .data_i(serial_in_line_i),
      .readback_i(reg_reset_readback[`BIT_READBACK_ENABLE]),
      .read_data_i(read_data),
      .read_addr_o(read_addr),
      .word_valid_o(word_valid),
      .word_o(word),
      .serial_out_o(shifted_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         serial_out_line_o <= 1'b0;
         readback_enable_o <= 1'b0;
         low_rate_mode_o <= 1'b0;
         reference_select_o <= 2'h0;
         standby_o <= 1'b0;
         power_mode_o <= 4'h0;
         output_is_lvds_o <= 1'b0;
         clock_edge_o <= 6'h00;
         chan_ctrl_enable_o <= 1'b0;
         user_pattern_o <= 14'h0000;
         offset_loop_a_o <= 1'b0;
         gain_setting_a_o <= 4'h0;
         offset_tc_a_o <= 4'h0;
      end else begin
         serial_out_line_o <= shifted_out & reg_reset_readback[`BIT_READBACK_ENABLE];
         readback_enable_o <= reg_reset_readback[`BIT_READBACK_ENABLE];
         low_rate_mode_o <= reg_low_rate[`BIT_LOW_RATE];
         reference_select_o <= reg_reference[`REF_SEL_HI:`REF_SEL_LO];
         standby_o <= reg_reference[`BIT_STANDBY];
         power_mode_o <= reg_power_state[`PWR_MODE_HI:`PWR_MODE_LO];
         output_is_lvds_o <= reg_output_if[`BIT_OUTPUT_IF];
         clock_edge_o <= reg_clock_edge[`EDGE_HI:`EDGE_LO];
         chan_ctrl_enable_o <= reg_chan_enable[`BIT_CHAN_ENABLE];
         user_pattern_o <= {reg_pattern_high[`PATTERN_HIGH_HI:0], reg_pattern_low};
         offset_loop_a_o <= reg_offset_loop_a[`BIT_OFFSET_LOOP_A];
         gain_setting_a_o <= reg_gain_tc_a[`GAIN_A_HI:`GAIN_A_LO];
         offset_tc_a_o <= reg_gain_tc_a[`TC_A_HI:`TC_A_LO];
      end
   end
endmodule
`default_nettype wire

// ### rtl/serial_config_regs.vh
// register offsets, field positions, reset values and timing counts of the configuration port
`ifndef SERIAL_CONFIG_REGS_VH
`define SERIAL_CONFIG_REGS_VH
`define ADDR_RESET_READBACK 8'h00
`define ADDR_LOW_RATE 8'h20
`define ADDR_REFERENCE 8'h3F
`define ADDR_POWER_STATE 8'h40
`define ADDR_OUTPUT_IF 8'h41
`define ADDR_CLOCK_EDGE 8'h44
`define ADDR_CHAN_ENABLE 8'h50
`define ADDR_PATTERN_LOW 8'h51
`define ADDR_PATTERN_HIGH 8'h52
`define ADDR_OFFSET_LOOP_A 8'h53
`define ADDR_GAIN_TC_A 8'h55
`define BIT_SOFT_RESET 7
`define BIT_READBACK_ENABLE 0
`define BIT_LOW_RATE 2
`define BIT_STANDBY 1
`define BIT_OUTPUT_IF 7
`define BIT_CHAN_ENABLE 0
`define BIT_OFFSET_LOOP_A 6
`define REF_SEL_HI 6
`define REF_SEL_LO 5
`define GAIN_A_HI 7
`define GAIN_A_LO 4
`define TC_A_HI 3
`define TC_A_LO 0
`define PWR_MODE_HI 3
`define PWR_MODE_LO 0
`define EDGE_HI 7
`define EDGE_LO 2
`define PATTERN_HIGH_HI 5
`define MASK_RESET_READBACK 8'h01
`define MASK_LOW_RATE 8'h04
`define MASK_REFERENCE 8'h62
`define MASK_POWER_STATE 8'h0F
`define MASK_OUTPUT_IF 8'h80
`define MASK_CLOCK_EDGE 8'hFC
`define MASK_CHAN_ENABLE 8'h01
`define MASK_PATTERN_LOW 8'hFF
`define MASK_PATTERN_HIGH 8'h3F
`define MASK_OFFSET_LOOP_A 8'h40
`define MASK_GAIN_TC_A 8'hFF
`define REG_RESET_VALUE 8'h00
`define FRAME_BITS 16
`define ADDR_BITS 8
`define CLK_PERIOD_PS 5000
`define HW_RESET_MAX_NS 1000
`define HW_RESET_MAX_CYCLES ((`HW_RESET_MAX_NS * 1000) / `CLK_PERIOD_PS)
`endif

// ### rtl/serial_frame_shifter.v
// shifts 16-bit serial frames in on falling shift clock edges and drives readback bits
`timescale 1ns/1ps
`default_nettype none
`include "serial_config_regs.vh"
module serial_frame_shifter (
   input wire clk_i,
   input wire rst_b_i,
   input wire sclk_i,
   input wire select_n_i,
   input wire data_i,
   input wire readback_i,
   input wire [7:0] read_data_i,
   output reg [7:0] read_addr_o,
   output reg word_valid_o,
   output reg [15:0] word_o,
   output reg serial_out_o
);
   ////////////////////////////////////////////////////////////////////////////////
   reg [2:0] sclk_sync;
   reg [1:0] sel_sync;
   reg [1:0] dat_sync;
   reg [3:0] bit_count;
   reg [14:0] shift;
   reg [7:0] out_shift;
   reg load_msb;
   wire fall;
   wire rise;
   wire active;
   // sync stage 0 read only by stage 1; edges use stages 1 and 2
   assign fall = sclk_sync[2] & ~sclk_sync[1];
   assign rise = ~sclk_sync[2] & sclk_sync[1];
   assign active = ~sel_sync[1];
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         // shift clock idles high, so no false rise right after reset
         sclk_sync <= 3'h7;
         sel_sync <= 2'h3;
         dat_sync <= 2'h0;
      end else begin
         sclk_sync <= {sclk_sync[1:0], sclk_i};
         sel_sync <= {sel_sync[0], select_n_i};
         dat_sync <= {dat_sync[0], data_i};
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bit_count <= 4'h0;
         shift <= 15'h0000;
         word_valid_o <= 1'b0;
         word_o <= 16'h0000;
         read_addr_o <= 8'h00;
         load_msb <= 1'b0;
      end else begin
         word_valid_o <= 1'b0;
         load_msb <= 1'b0;
         if (!active) begin
            // leftover bits of a short frame are dropped
            bit_count <= 4'h0;
         end else if (fall) begin
            shift <= {shift[13:0], dat_sync[1]};
            bit_count <= bit_count + 4'h1;
            if (bit_count == 4'h7) begin
               read_addr_o <= {shift[6:0], dat_sync[1]};
               load_msb <= 1'b1;
            end
            if (bit_count == 4'hF) begin
               word_o <= {shift, dat_sync[1]};
               word_valid_o <= 1'b1;
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // bits after the first change on rising edges so the controller can take them on falling edges; the first is loaded after the eighth fall
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_shift <= 8'h00;
         serial_out_o <= 1'b0;
      end else if (!readback_i) begin
         serial_out_o <= 1'b0;
      end else if (!active) begin
         serial_out_o <= 1'b0;
      end else if (load_msb) begin
         // address register settles one clock before its data is looked up
         out_shift <= {read_data_i[6:0], 1'b0};
         serial_out_o <= read_data_i[7];
      end else if (rise && bit_count > 4'h8) begin
         serial_out_o <= out_shift[7];
         out_shift <= {out_shift[6:0], 1'b0};
      end else if (fall && bit_count == 4'hF) begin
         serial_out_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire
